// ### logic/pirq_pkg.sv
// package: register map, field positions and encodings of the peripheral irq flag block
package pirq_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bus shape
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned REG_W  = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam logic [ADR_W-1:0] FLAGS_OFS   = 8'h0c;
    localparam logic [ADR_W-1:0] ENABLES_OFS = 8'h8c;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions, shared by flags and enables
    localparam int unsigned WIDE_OVF_BIT     = 0;
    localparam int unsigned PERIOD_MATCH_BIT = 1;
    localparam int unsigned CAPCMP_BIT       = 2;
    localparam int unsigned CONV_DONE_BIT    = 6;

    // implemented positions; bit 7 and bits 5..3 stay zero
    localparam logic [REG_W-1:0] IMPL_MASK = 8'h47;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [REG_W-1:0] FLAGS_RST   = 8'h00;
    localparam logic [REG_W-1:0] ENABLES_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // capture/compare unit modes
    typedef enum logic [1:0] {
        CAPCMP_OFF,
        CAPCMP_CAPTURE,
        CAPCMP_COMPARE,
        CAPCMP_PWM
    } pirq_capcmp_mode_type;

endpackage

// ### logic/pirq_flag_regs.sv
// peripheral interrupt flag and enable registers behind a classic wishbone slave
//
// Notes on behaviour
// R1: a flag sets on its event whatever its own enable or the global enable.
// R2: software should clear a flag before setting its enable bit.
// R3: converter-done flag, bit 6, sets on conversion end, held until written zero.
// R4: capture mode: bit 2 sets on timer capture, held; unused in pulse-width mode.
// R5: compare mode: bit 2 sets on timer compare match, held until cleared.
// R6: bit 1 sets when period timer count equals period value, held until cleared. The code sets it only in the cycle equality begins, not while it lasts.
// R7: bit 0 sets on wide timer overflow, held until written zero.
// R8: bit 7 and bits 5..3 always read zero; writes there do nothing.
// R9: enable register, same layout, lets a set flag raise the interrupt request.
// R10: flags and enables reset to zero; a write stores the written value.
// R11: an event in the same cycle as a software clear wins.
//
// Our own choice: the Wishbone interface to the registers.
module pirq_flag_regs
    import pirq_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [ADR_W-1:0]     adr_i,
    input  wire logic [DAT_W/8-1:0]   sel_i,
    input  wire logic [DAT_W-1:0]     dat_i,
    output logic      [DAT_W-1:0]     dat_o,
    output logic                      ack_o,
    // peripheral events
    input  wire logic                 conv_done_i,
    input  wire logic                 capture_i,
    input  wire logic                 compare_match_i,
    input  wire logic [1:0]           capcmp_mode_i,
    input  wire logic [REG_W-1:0]     period_timer_i,
    input  wire logic [REG_W-1:0]     period_value_i,
    input  wire logic                 wide_timer_ovf_i,
    // interrupt request
    output logic                      irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [REG_W-1:0]     flags_q;
    logic [REG_W-1:0]     flags_d;
    logic [REG_W-1:0]     enables_q;
    logic [REG_W-1:0]     enables_d;
    logic [REG_W-1:0]     events;
    logic [REG_W-1:0]     rd_val;
    logic                 ack_q;
    logic [DAT_W-1:0]     dat_q;
    logic                 req;
    logic                 wr_commit;
    logic                 wr_flags;
    logic                 wr_enables;
    logic                 period_eq;
    logic                 period_eq_q;
    logic                 capture_evt;
    logic                 compare_evt;
    pirq_capcmp_mode_type capcmp_mode;

    assign capcmp_mode = pirq_capcmp_mode_type'(capcmp_mode_i);

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone handshake
    // ack one cycle after the request; writes commit at the edge that samples ack,
    // so the master's held data is the data stored
    assign req       = cyc_i && stb_i;
    assign wr_commit = req && we_i && ack_q && sel_i[0];
    assign wr_flags   = wr_commit && (adr_i == FLAGS_OFS);
    assign wr_enables = wr_commit && (adr_i == ENABLES_OFS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // unmapped addresses are acknowledged and read zero
    always_comb begin
        if (adr_i == FLAGS_OFS) begin
            rd_val = flags_q & IMPL_MASK; // R8
        end else if (adr_i == ENABLES_OFS) begin
            rd_val = enables_q & IMPL_MASK; // R8
        end else begin
            rd_val = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (req && !ack_q) begin
            dat_q <= {{(DAT_W-REG_W){1'b0}}, rd_val};
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////////////
    // event detection
    // period match taken on the rising edge of equality, so a match that lasts
    // several cycles does not refill a flag that software just cleared
    assign period_eq   = (period_timer_i == period_value_i);
    assign capture_evt = capture_i && (capcmp_mode == CAPCMP_CAPTURE); // R4
    assign compare_evt = compare_match_i && (capcmp_mode == CAPCMP_COMPARE); // R5

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_eq_q <= 1'b1;
        end else begin
            period_eq_q <= period_eq;
        end
    end

    always_comb begin
        events                   = '0;
        events[CONV_DONE_BIT]    = conv_done_i; // R3
        events[CAPCMP_BIT]       = capture_evt || compare_evt; // R4
        events[PERIOD_MATCH_BIT] = period_eq && !period_eq_q; // R6
        events[WIDE_OVF_BIT]     = wide_timer_ovf_i; // R7
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flag register
    // events are or-ed in after the write so a clear never hides a new event
    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = dat_i[REG_W-1:0]; // R10
        end
        flags_d = (flags_d | events) & IMPL_MASK; // R1 R11 R8
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= FLAGS_RST; // R10
        end else begin
            flags_q <= flags_d; // R3 R4 R5 R6 R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // enable register
    always_comb begin
        enables_d = enables_q;
        if (wr_enables) begin
            enables_d = dat_i[REG_W-1:0] & IMPL_MASK; // R8 R10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enables_q <= ENABLES_RST; // R10
        end else begin
            enables_q <= enables_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt request: level, high while any enabled flag is set
    assign irq_o = |(flags_q & enables_q); // R9

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_req_taken;
        req && !ack_q;
    endsequence

    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence

    sequence s_flag_clear_with_event;
        wr_flags && !dat_i[CONV_DONE_BIT] && conv_done_i;
    endsequence

    sequence s_read_taken;
        req && !ack_q && !we_i;
    endsequence

    sequence s_ovf_clear_with_event;
        wr_flags && !dat_i[WIDE_OVF_BIT] && wide_timer_ovf_i;
    endsequence

    sequence s_quiet_write;
        req && we_i && ack_q && (events == '0);
    endsequence

    AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req_taken |=> s_ack_pulse)
        else $error("ack did not follow a request for exactly one cycle");

    AST_CONV_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        conv_done_i |=> flags_q[CONV_DONE_BIT])
        else $error("conversion end did not set its flag");

    AST_CAPTURE_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        capture_i && capcmp_mode_i == 2'h1 |=> flags_q[CAPCMP_BIT])
        else $error("capture did not set the capture/compare flag");

    AST_COMPARE_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        compare_match_i && capcmp_mode_i == 2'h2 |=> flags_q[CAPCMP_BIT])
        else $error("compare match did not set the capture/compare flag");

    AST_PWM_UNUSED: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        capcmp_mode_i == 2'h3 && !flags_q[CAPCMP_BIT]
            && !(wr_flags && dat_i[CAPCMP_BIT])
        |=> !flags_q[CAPCMP_BIT])
        else $error("capture/compare flag set in pulse-width mode");

    // equality history restarts as equal, so no edge is owed right after reset
    AST_PERIOD_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        !$past(rst_i) && $rose(period_timer_i == period_value_i)
        |=> flags_q[PERIOD_MATCH_BIT])
        else $error("period match did not set its flag");

    AST_OVF_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        wide_timer_ovf_i |=> flags_q[WIDE_OVF_BIT])
        else $error("overflow did not set its flag");

    AST_FLAGS_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        !wr_flags |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("a flag fell without a software write");

    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        ack_o && $past(adr_i == FLAGS_OFS || adr_i == ENABLES_OFS)
        |-> (dat_o[7] == 1'b0) && (dat_o[5:3] == 3'h0))
        else $error("unimplemented bit read back as one");

    AST_ENABLE_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        ##1 (irq_o == |($past(flags_d) & $past(enables_d))))
        else $error("interrupt request does not match flags and enables");

    AST_EVENT_NO_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        conv_done_i && enables_q == 8'h00 && !wr_enables
        |=> flags_q[CONV_DONE_BIT] && !irq_o)
        else $error("masked event was not latched or raised the request");

    AST_WRITE_STORE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        wr_flags && events == 8'h00 |=> flags_q == ($past(dat_i[7:0]) & 8'h47))
        else $error("flag write did not store the written value");

    AST_RESET_ZERO: assert property (@(posedge clk_i) // R10
        rst_i |=> flags_q == 8'h00 && enables_q == 8'h00 && !irq_o)
        else $error("flags or enables not zero after reset");

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        s_flag_clear_with_event |=> flags_q[CONV_DONE_BIT])
        else $error("event lost to a same-cycle clear");

    AST_ACK_NEEDS_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> $past(req))
        else $error("ack without a request");

    AST_DAT_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        dat_o[DAT_W-1:REG_W] == '0)
        else $error("read data above the register byte is not zero");

    AST_READ_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        s_read_taken ##0 (adr_i == FLAGS_OFS) |=> dat_o[REG_W-1:0] == $past(flags_q))
        else $error("flag read returned a wrong value");

    AST_READ_ENABLES: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        s_read_taken ##0 (adr_i == ENABLES_OFS) |=> dat_o[REG_W-1:0] == $past(enables_q))
        else $error("enable read returned a wrong value");

    AST_READ_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_taken ##0 (adr_i != FLAGS_OFS && adr_i != ENABLES_OFS)
        |=> dat_o == '0)
        else $error("unmapped read did not return zero");

    AST_FLAGS_RSVD: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (flags_q & ~IMPL_MASK) == '0)
        else $error("unimplemented flag bit stored a one");

    AST_ENABLES_RSVD: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (enables_q & ~IMPL_MASK) == '0)
        else $error("unimplemented enable bit stored a one");

    AST_ENABLES_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        !wr_enables |=> $stable(enables_q))
        else $error("enables changed without a write");

    AST_ENABLE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        wr_enables |=> enables_q == ($past(dat_i[REG_W-1:0]) & IMPL_MASK))
        else $error("enable write did not store the written value");

    AST_UNMAPPED_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_quiet_write ##0 (adr_i != FLAGS_OFS && adr_i != ENABLES_OFS)
        |=> $stable(flags_q) && $stable(enables_q))
        else $error("unmapped write changed a register");

    AST_IRQ_MASKED: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        enables_q == '0 |-> !irq_o)
        else $error("interrupt request with every source masked");

    AST_IRQ_NEEDS_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        flags_q == '0 |-> !irq_o)
        else $error("interrupt request with no flag set");

    AST_IRQ_CONV: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        flags_q[CONV_DONE_BIT] && enables_q[CONV_DONE_BIT] |-> irq_o)
        else $error("enabled conversion flag did not raise the request");

    AST_OVF_IRQ: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        wide_timer_ovf_i && enables_q[WIDE_OVF_BIT] && !wr_enables |=> irq_o)
        else $error("enabled overflow did not raise the request next cycle");

    AST_COMPARE_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        compare_match_i && !capture_i && capcmp_mode_i == 2'h1 && !flags_q[CAPCMP_BIT]
            && !(wr_flags && dat_i[CAPCMP_BIT])
        |=> !flags_q[CAPCMP_BIT])
        else $error("compare match counted in capture mode");

    AST_CAPTURE_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        capture_i && !compare_match_i && capcmp_mode_i == 2'h2 && !flags_q[CAPCMP_BIT]
            && !(wr_flags && dat_i[CAPCMP_BIT])
        |=> !flags_q[CAPCMP_BIT])
        else $error("capture counted in compare mode");

    AST_RESET_BUS: assert property (@(posedge clk_i)
        rst_i |=> !ack_o && dat_o == '0)
        else $error("bus outputs not idle after reset");

    AST_DAT_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
        !req || ack_q |=> $stable(dat_o))
        else $error("read data changed without a new request");

    AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack stood for more than one cycle");

    AST_FLAG_WRITE_ONE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        wr_flags && dat_i[WIDE_OVF_BIT] |=> flags_q[WIDE_OVF_BIT])
        else $error("writing one did not set the overflow flag");

    AST_CLEAR_NO_EVENT: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        wr_flags && !dat_i[CONV_DONE_BIT] && !conv_done_i |=> !flags_q[CONV_DONE_BIT])
        else $error("writing zero did not clear the conversion flag");

    AST_OVF_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        s_ovf_clear_with_event |=> flags_q[WIDE_OVF_BIT])
        else $error("overflow lost to a same-cycle clear");

endmodule

// ### verif/pirq_event_src.sv
// partner model: peripheral event sources and the period timer
module pirq_event_src
    import pirq_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // commands from the bench: conv, capture, compare, overflow
    input  wire logic [3:0]       ev_i,
    input  wire logic             run_i,
    input  wire logic [REG_W-1:0] pv_i,
    // event lines towards the flag block
    output logic                  conv_done_o,
    output logic                  capture_o,
    output logic                  compare_match_o,
    output logic                  ovf_o,
    output logic [REG_W-1:0]      count_o
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk_i) begin
        {conv_done_o, capture_o, compare_match_o, ovf_o} <= rst_i ? 4'h0 : ev_i;
    end

    // equal for one cycle only: the timer wraps on the match
    always_ff @(posedge clk_i) begin
        if (rst_i || count_o == pv_i) count_o <= 8'h00;
        else if (run_i) count_o <= count_o + 8'h01;
    end
endmodule

// ### verif/tb_top.sv
// testbench: register access, event sources and interrupt output
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pirq_pkg::*;

    logic             clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic             run = 1'b0, ack_o, irq_o, cd, cap, cmp, ovf;
    logic [ADR_W-1:0] adr_i = 8'h00;
    logic [3:0]       sel_i = 4'h0, ev = 4'h0;
    logic [DAT_W-1:0] dat_i = 32'h0, dat_o;
    logic [1:0]       mode = 2'h0;
    logic [REG_W-1:0] pv = 8'h05, cnt;
    int               failures = 0, cmp_count = 0, cyc_cnt = 0;
    // mode, event command, expected flags
    logic [13:0]      tab [7] = '{14'h1840, 14'h1404, 14'h2400, 14'h2204,
                                  14'h1200, 14'h3600, 14'h0101};

    always #12.5 clk_i = ~clk_i;

    pirq_flag_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .conv_done_i(cd), .capture_i(cap), .compare_match_i(cmp),
        .capcmp_mode_i(mode), .period_timer_i(cnt), .period_value_i(pv),
        .wide_timer_ovf_i(ovf), .irq_o(irq_o));

    pirq_event_src src (.clk_i(clk_i), .rst_i(rst_i), .ev_i(ev), .run_i(run), .pv_i(pv),
        .conv_done_o(cd), .capture_o(cap), .compare_match_o(cmp), .ovf_o(ovf),
        .count_o(cnt));

    task automatic test_done();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(string n, logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask

    // e fires events so they land on the edge where the access takes effect
    task automatic wb_acc(logic w, logic [7:0] a, logic [7:0] d, logic [3:0] e,
                          output logic [31:0] q);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, ev} <= {2'b11, w, a, 4'hf, 24'h0, d, e};
        @(posedge clk_i);
        ev <= 4'h0;
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask

    task automatic wb_write(logic [7:0] a, logic [7:0] d, logic [3:0] e = 4'h0);
        logic [31:0] q;
        wb_acc(1'b1, a, d, e, q);
    endtask

    task automatic rd_chk(logic [7:0] a, logic [7:0] exp, string n);
        logic [31:0] q;
        wb_acc(1'b0, a, 8'h00, 4'h0, q);
        check(n, q, {24'h0, exp});
    endtask

    task automatic pulse(logic [3:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 4'h0;
    endtask

    always @(posedge clk_i) begin
        cyc_cnt++;
    end

    task automatic run_tests();
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(FLAGS_OFS, 8'h00, "flags reset");
        rd_chk(ENABLES_OFS, 8'h00, "enables reset");
        wb_write(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00, "unmapped");
        for (int i = 0; i < 7; i++) begin
            wb_write(FLAGS_OFS, 8'h00);
            mode <= tab[i][13:12];
            pulse(tab[i][11:8]);
            rd_chk(FLAGS_OFS, tab[i][7:0], "event flags");
            check("irq masked", {31'h0, irq_o}, 32'h0);
        end
        wb_write(FLAGS_OFS, 8'h00);
        run <= 1'b1;
        repeat (12) @(posedge clk_i);
        run <= 1'b0;
        rd_chk(FLAGS_OFS, 8'h02, "period match");
        wb_write(FLAGS_OFS, 8'hff);
        rd_chk(FLAGS_OFS, 8'h47, "flags write one");
        wb_write(FLAGS_OFS, 8'h00);
        rd_chk(FLAGS_OFS, 8'h00, "flags cleared");
        // flags clear before enabling, so no stale request
        wb_write(ENABLES_OFS, 8'hff);
        rd_chk(ENABLES_OFS, 8'h47, "enables");
        check("irq idle", {31'h0, irq_o}, 32'h0);
        pulse(4'h1);
        // flag lands one edge after the event line, irq is seen the edge after
        repeat (2) @(posedge clk_i);
        check("irq raised", {31'h0, irq_o}, 32'h1);
        wb_write(ENABLES_OFS, 8'h46);
        // the mask is stored at the ack edge, so look one edge later
        @(posedge clk_i);
        check("irq masked off", {31'h0, irq_o}, 32'h0);
        wb_write(FLAGS_OFS, 8'h00, 4'h9);
        rd_chk(FLAGS_OFS, 8'h41, "event beats clear");
        check("irq conv", {31'h0, irq_o}, 32'h1);
    endtask

    // the cycle ceiling races the tests; whichever ends first closes the run
    initial begin
        fork
            run_tests();
            begin
                wait (cyc_cnt == 5000);
                failures++;
            end
        join_any
        test_done();
    end
endmodule
